/* File: design/port_pin_pkg.sv */
`default_nettype none
package port_pin_pkg;
  localparam int          NPINS   = 8;
  localparam int          AW      = 8;
  // register byte offsets
  localparam logic [7:0] OFF_DATA     = 8'h00;
  localparam logic [7:0] OFF_DIR      = 8'h04;
  localparam logic [7:0] OFF_DATA_IN  = 8'h08;
  localparam logic [7:0] OFF_PULL_EN  = 8'h0c;
  localparam logic [7:0] OFF_PULL_SEL = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h14;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h18;
  localparam logic [7:0] OFF_WIRED_OR = 8'h1c;
  localparam logic [7:0] OFF_EDGE_SEL = 8'h20;
  localparam logic [7:0] OFF_PKG_CODE = 8'h24;
  localparam logic [7:0] OFF_ROUTE    = 8'h28;
  // reset values
  localparam logic [7:0] RST_PIN_REG  = 8'h00;
  localparam logic [2:0] RST_PKG_CODE = 3'h0;
  localparam logic [1:0] RST_ROUTE    = 2'h0;
  // field positions in the routing register
  localparam int ROUTE_B_EN   = 0;
  localparam int ROUTE_RX_ALT = 1;
  // pins whose output stage can emulate open drain
  localparam logic [7:0] WOR_CAPABLE  = 8'hf0;
  // bonded pins for each package code
  localparam logic [7:0] PIN_AVAIL [8] = '{
    8'h0f, 8'h3f, 8'hff, 8'hff, 8'h0f, 8'h3f, 8'hff, 8'hff
  };
endpackage : port_pin_pkg
`default_nettype wire

/* File: design/port_pin_logic.sv */
// Chosen here: the Wishbone slave port and the placing of the registers.
`default_nettype none
module port_pin_logic
  import port_pin_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [AW-1:0]     wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NPINS-1:0]  pad_in,
  output logic      [NPINS-1:0]  pad_out,
  output logic      [NPINS-1:0]  pad_oe,
  output logic      [NPINS-1:0]  pad_pull_en,
  output logic      [NPINS-1:0]  pad_pull_up,
  input  wire logic [NPINS-1:0]  pa_req,
  input  wire logic [NPINS-1:0]  pa_oe,
  input  wire logic [NPINS-1:0]  pa_out,
  input  wire logic [NPINS-1:0]  pb_req,
  input  wire logic [NPINS-1:0]  pb_oe,
  input  wire logic [NPINS-1:0]  pb_out,
  input  wire logic [NPINS-1:0]  rx_req,
  output logic      [NPINS-1:0]  periph_in,
  input  wire logic [2:0]        nvm_code,
  input  wire logic              nvm_valid,
  output logic                   port_irq,
  output logic                   stop_wake
);

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0]    off);
    hit = (a[AW-1:2] == off[AW-1:2]);
  endfunction : hit

  // pin synchroniser
  logic [NPINS-1:0] sync1_q, sync1_d;
  logic [NPINS-1:0] pin_q, pin_d;
  logic [NPINS-1:0] pin_prev_q, pin_prev_d;

  // configuration state
  logic [NPINS-1:0] data_q, data_d;
  logic [NPINS-1:0] dir_q, dir_d;
  logic [NPINS-1:0] pull_en_q, pull_en_d;
  logic [NPINS-1:0] pull_sel_q, pull_sel_d;
  logic [NPINS-1:0] irq_en_q, irq_en_d;
  logic [NPINS-1:0] flag_q, flag_d;
  logic [NPINS-1:0] wor_q, wor_d;
  logic [NPINS-1:0] edge_sel_q, edge_sel_d;
  logic [2:0]       pkg_q, pkg_d;
  logic             pkg_loaded_q, pkg_loaded_d;
  logic             pkg_locked_q, pkg_locked_d;
  logic [1:0]       route_q, route_d;

  // bus state
  logic             ack_q, ack_d;
  logic [31:0]      rdat_q, rdat_d;
  logic             wake_q, wake_d;

  // register select, decoded once for both reads and writes
  logic             sel_data;
  logic             sel_dir;
  logic             sel_data_in;
  logic             sel_pull_en;
  logic             sel_pull_sel;
  logic             sel_irq_en;
  logic             sel_irq_flag;
  logic             sel_wired_or;
  logic             sel_edge_sel;
  logic             sel_pkg_code;
  logic             sel_route;

  logic             req;
  logic             wr;
  logic [NPINS-1:0] wbyte;
  logic [NPINS-1:0] edge_ev;
  logic [NPINS-1:0] avail;
  logic [NPINS-1:0] own;
  logic [NPINS-1:0] rx_pins;
  logic [NPINS-1:0] data_view;

  assign req   = wb_cyc_i & wb_stb_i;
  // a write takes effect on the edge that the master sees ack
  assign wr    = req & wb_we_i & ack_q & wb_sel_i[0];
  assign wbyte = wb_dat_i[NPINS-1:0];

  // unmapped offsets leave every select low, so they read zero
  // and a write to them changes nothing
  always_comb begin
    sel_data     = 1'b0;
    sel_dir      = 1'b0;
    sel_data_in  = 1'b0;
    sel_pull_en  = 1'b0;
    sel_pull_sel = 1'b0;
    sel_irq_en   = 1'b0;
    sel_irq_flag = 1'b0;
    sel_wired_or = 1'b0;
    sel_edge_sel = 1'b0;
    sel_pkg_code = 1'b0;
    sel_route    = 1'b0;
    if (hit(wb_adr_i, OFF_DATA)) begin
      sel_data = 1'b1;
    end else if (hit(wb_adr_i, OFF_DIR)) begin
      sel_dir = 1'b1;
    end else if (hit(wb_adr_i, OFF_DATA_IN)) begin
      sel_data_in = 1'b1;
    end else if (hit(wb_adr_i, OFF_PULL_EN)) begin
      sel_pull_en = 1'b1;
    end else if (hit(wb_adr_i, OFF_PULL_SEL)) begin
      sel_pull_sel = 1'b1;
    end else if (hit(wb_adr_i, OFF_IRQ_EN)) begin
      sel_irq_en = 1'b1;
    end else if (hit(wb_adr_i, OFF_IRQ_FLAG)) begin
      sel_irq_flag = 1'b1;
    end else if (hit(wb_adr_i, OFF_WIRED_OR)) begin
      sel_wired_or = 1'b1;
    end else if (hit(wb_adr_i, OFF_EDGE_SEL)) begin
      sel_edge_sel = 1'b1;
    end else if (hit(wb_adr_i, OFF_PKG_CODE)) begin
      sel_pkg_code = 1'b1;
    end else if (hit(wb_adr_i, OFF_ROUTE)) begin
      sel_route = 1'b1;
    end
  end

  // routing: pure combinational decode of package code and route bits
  assign avail   = PIN_AVAIL[pkg_q];
  // alternate mapping swaps the receive-only input between the low and high pin nibbles
  assign rx_pins = route_q[ROUTE_RX_ALT] ?
                   {rx_req[3:0], rx_req[7:4]} : rx_req;

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      logic a_own;
      logic b_own;
      logic r_own;
      logic drive;
      logic val;
      // fixed priority: peripheral a, then b, then receive-only
      assign a_own = pa_req[i] & avail[i];
      assign b_own = pb_req[i] & avail[i] & route_q[ROUTE_B_EN]
                     & ~a_own;
      assign r_own = rx_pins[i] & avail[i] & ~a_own
                     & ~b_own;
      assign own[i] = a_own | b_own | r_own;
      always_comb begin
        if (a_own) begin
          drive = pa_oe[i];
          val   = pa_out[i];
        end else if (b_own) begin
          drive = pb_oe[i];
          val   = pb_out[i];
        end else if (r_own) begin
          drive = 1'b0;
          val   = 1'b0;
        end else begin
          drive = dir_q[i];
          val   = data_q[i];
        end
      end
      // open-drain emulation: release the pin instead of driving high
      assign pad_oe[i]  = drive & ~(wor_q[i] & WOR_CAPABLE[i]
                                    & val);
      assign pad_out[i] = val;
      assign pad_pull_en[i] = pull_en_q[i] & ~pad_oe[i];
      assign pad_pull_up[i] = pull_sel_q[i];
      assign data_view[i]   = dir_q[i] ? data_q[i]
                                       : pin_q[i];
    end
  endgenerate

  assign periph_in = pin_q;
  // edge detector reads the pad itself, so driven pins count too
  assign edge_ev = (edge_sel_q & pin_q & ~pin_prev_q)
                 | (~edge_sel_q & ~pin_q & pin_prev_q);

  assign port_irq  = |(flag_q & irq_en_q);
  assign stop_wake = wake_q;
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;

  // synchroniser and edge history
  always_comb begin
    sync1_d    = pad_in;
    pin_d      = sync1_q;
    pin_prev_d = pin_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q    <= RST_PIN_REG;
      pin_q      <= RST_PIN_REG;
      pin_prev_q <= RST_PIN_REG;
    end else begin
      sync1_q    <= sync1_d;
      pin_q      <= pin_d;
      pin_prev_q <= pin_prev_d;
    end
  end

  // pin configuration registers
  always_comb begin
    data_d     = data_q;
    dir_d      = dir_q;
    pull_en_d  = pull_en_q;
    pull_sel_d = pull_sel_q;
    irq_en_d   = irq_en_q;
    wor_d      = wor_q;
    edge_sel_d = edge_sel_q;
    route_d    = route_q;
    if (wr) begin
      // data stores even while a peripheral owns the pin
      if (sel_data) begin
        data_d = wbyte;
      end else if (sel_dir) begin
        dir_d = wbyte;
      end else if (sel_pull_en) begin
        pull_en_d = wbyte;
      end else if (sel_pull_sel) begin
        pull_sel_d = wbyte;
      end else if (sel_irq_en) begin
        irq_en_d = wbyte;
      end else if (sel_wired_or) begin
        wor_d = wbyte;
      end else if (sel_edge_sel) begin
        edge_sel_d = wbyte;
      end else if (sel_route) begin
        route_d = wbyte[1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      data_q     <= RST_PIN_REG;
      dir_q      <= RST_PIN_REG;
      pull_en_q  <= RST_PIN_REG;
      pull_sel_q <= RST_PIN_REG;
      irq_en_q   <= RST_PIN_REG;
      wor_q      <= RST_PIN_REG;
      edge_sel_q <= RST_PIN_REG;
      route_q    <= RST_ROUTE;
    end else begin
      data_q     <= data_d;
      dir_q      <= dir_d;
      pull_en_q  <= pull_en_d;
      pull_sel_q <= pull_sel_d;
      irq_en_q   <= irq_en_d;
      wor_q      <= wor_d;
      edge_sel_q <= edge_sel_d;
      route_q    <= route_d;
    end
  end

  // interrupt flags and wake pulse
  always_comb begin
    flag_d = flag_q;
    // an edge in the same cycle as a clear wins
    if (wr && sel_irq_flag) begin
      flag_d = flag_q & ~wbyte;
    end
    flag_d = flag_d | edge_ev;
    wake_d = |(edge_ev & irq_en_q);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      flag_q <= RST_PIN_REG;
      wake_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      wake_q <= wake_d;
    end
  end

  // package code: nonvolatile load first, then a single software write
  always_comb begin
    pkg_d        = pkg_q;
    pkg_loaded_d = pkg_loaded_q;
    pkg_locked_d = pkg_locked_q;
    if (nvm_valid && !pkg_loaded_q) begin
      pkg_d        = nvm_code;
      pkg_loaded_d = 1'b1;
    end
    // a software write also blocks any later factory load
    if (wr && sel_pkg_code && !pkg_locked_q) begin
      pkg_d        = wbyte[2:0];
      pkg_loaded_d = 1'b1;
      pkg_locked_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pkg_q        <= RST_PKG_CODE;
      pkg_loaded_q <= 1'b0;
      pkg_locked_q <= 1'b0;
    end else begin
      pkg_q        <= pkg_d;
      pkg_loaded_q <= pkg_loaded_d;
      pkg_locked_q <= pkg_locked_d;
    end
  end

  // bus slave: ack one cycle after the request, data registered with it
  always_comb begin
    ack_d  = req & ~ack_q;
    rdat_d = '0;
    if (req && !ack_q && !wb_we_i) begin
      if (sel_data) begin
        rdat_d[NPINS-1:0] = data_view;
      end else if (sel_dir) begin
        rdat_d[NPINS-1:0] = dir_q;
      end else if (sel_data_in) begin
        rdat_d[NPINS-1:0] = pin_q;
      end else if (sel_pull_en) begin
        rdat_d[NPINS-1:0] = pull_en_q;
      end else if (sel_pull_sel) begin
        rdat_d[NPINS-1:0] = pull_sel_q;
      end else if (sel_irq_en) begin
        rdat_d[NPINS-1:0] = irq_en_q;
      end else if (sel_irq_flag) begin
        rdat_d[NPINS-1:0] = flag_q;
      end else if (sel_wired_or) begin
        rdat_d[NPINS-1:0] = wor_q;
      end else if (sel_edge_sel) begin
        rdat_d[NPINS-1:0] = edge_sel_q;
      end else if (sel_pkg_code) begin
        rdat_d[2:0] = pkg_q;
      end else if (sel_route) begin
        rdat_d[1:0] = route_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

endmodule : port_pin_logic
`default_nettype wire

/* File: sim/port_pin_assertions.sv */
`default_nettype none
module port_pin_checker
  import port_pin_pkg::*;
(
  input wire logic             clock,
  input wire logic             srst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic             wb_ack_o,
  input wire logic [NPINS-1:0] pad_in,
  input wire logic [NPINS-1:0] pad_oe,
  input wire logic [NPINS-1:0] pad_pull_en,
  input wire logic [NPINS-1:0] pa_req,
  input wire logic [NPINS-1:0] pa_oe,
  input wire logic [NPINS-1:0] periph_in,
  input wire logic             port_irq,
  input wire logic             stop_wake
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_reset_state: assert property (
    disable iff (1'b0) srst |=> !wb_ack_o && !port_irq && !stop_wake
      && (pad_oe & ~pa_req) == 8'h00) else $error("reset state");
  a_irq_hold: assert property (
    $fell(port_irq) |-> $past(wb_ack_o && wb_we_i))
    else $error("irq dropped");
  a_owner_drive: assert property (
    ((pad_oe ^ pa_oe) & pa_req & 8'h0f) == 8'h00) else $error("owner oe");
  a_pull_off: assert property (
    (pad_pull_en & pad_oe) == 8'h00) else $error("pull on driven pin");
  a_sync_delay: assert property (
    !$past(srst) && !$past(srst, 2) |-> periph_in[3:0] == $past(pad_in[3:0], 2))
    else $error("sync delay");
  a_wake_cause: assert property (
    stop_wake |-> $past(periph_in) != $past(periph_in, 2))
    else $error("wake without edge");
endmodule : port_pin_checker
bind port_pin_logic port_pin_checker chk (.*);
`default_nettype wire

/* File: sim/pad_model.sv */
`default_nettype none
module pad_model (
  input  wire logic       clock,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pull_en,
  input  wire logic [7:0] pad_pull_up,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h00;
  // an undriven, unpulled pin changes every cycle
  always_ff @(posedge clock) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_en[i]) pad_in[i] = pad_pull_up[i];
      else pad_in[i] = float_q[i];
    end
  end
endmodule : pad_model
`default_nettype wire

/* File: sim/port_pin_logic_test.sv */
`default_nettype none
module port_pin_logic_test
  import port_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, srst = 1, nvm_valid = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = '0, pa_req = '0, pa_oe = '0, pa_out = '0;
  logic [7:0]  pb_req = '0, pb_oe = '0, pb_out = '0, rx_req = '0;
  logic [7:0]  ext_en = 8'hff, ext_val = '0, r, p;
  logic [7:0]  pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up, periph_in;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic [2:0]  nvm_code = '0;
  logic        wb_ack_o, port_irq, stop_wake;
  logic [31:0] exp_q[$];
  int          fails = 0, checked = 0, wakes = 0;
  always #2 clock = ~clock;
  port_pin_logic dut (.*);
  pad_model pads (.*);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic conclude();
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] e = 8'h00);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    if (!w) exp_q.push_back({24'h000000, e});
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  // read results are compared in order of issue
  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && !wb_we_i)
      check(wb_dat_o, exp_q.size() ? exp_q.pop_front() : 32'hdeadbeef);
  end
  always @(posedge clock) if (stop_wake === 1'b1) wakes++;
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    conclude();
  end
  initial begin
    logic [7:0] offs[10];
    offs = '{OFF_DATA, OFF_DIR, OFF_DATA_IN, OFF_PULL_EN, OFF_PULL_SEL,
             OFF_IRQ_EN, OFF_WIRED_OR, OFF_EDGE_SEL, OFF_ROUTE, 8'h2c};
    void'($urandom(90));
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    foreach (offs[i]) wb(0, offs[i], 8'h00);
    @(posedge clock) {nvm_valid, nvm_code} <= 4'hd;
    @(posedge clock) nvm_valid <= 1'b0;
    wb(0, OFF_PKG_CODE, 8'h00, 8'h05);
    wb(1, OFF_PKG_CODE, 8'h03);
    wb(1, OFF_PKG_CODE, 8'h06);
    wb(0, OFF_PKG_CODE, 8'h00, 8'h03);
    r = 8'($urandom);
    wb(1, OFF_DIR, 8'hff);
    wb(1, OFF_DATA, r);
    wb(0, OFF_DATA, 8'h00, r);
    @(negedge clock);
    check(pad_oe, 8'hff);
    check(pad_out, r);
    @(posedge clock) ext_val <= r;
    wb(1, OFF_WIRED_OR, 8'hf0);
    @(negedge clock);
    check(pad_oe, 8'h0f | (~r & 8'hf0));
    wb(0, OFF_DATA_IN, 8'h00, r);
    wb(1, OFF_WIRED_OR, 8'h00);
    p = 8'($urandom);
    wb(1, OFF_DIR, 8'h00);
    ext_en <= 8'h00;
    wb(1, OFF_PULL_EN, 8'hff);
    wb(1, OFF_PULL_SEL, p);
    wb(0, OFF_PULL_SEL, 8'h00, p);
    wb(0, OFF_DATA, 8'h00, p);
    @(negedge clock);
    check({pad_pull_en, pad_pull_up}, {8'hff, p});
    @(posedge clock) ext_en <= 8'hff;
    wb(1, OFF_PULL_EN, 8'h00);
    wb(1, OFF_DIR, 8'hff);
    {pa_req, pa_oe, pa_out} <= 24'h050404;
    {pb_req, pb_oe, pb_out} <= 24'h040400;
    rx_req <= 8'h02;
    wb(1, OFF_DATA, 8'hfb);
    @(negedge clock);
    check(pad_oe, 8'hfc);
    check(pad_out & 8'hfc, 8'hfc);
    wb(1, OFF_ROUTE, 8'h01);
    @(negedge clock);
    check(pad_out & 8'hfc, 8'hfc);
    @(posedge clock) pa_req <= 8'h01;
    @(negedge clock);
    check(pad_out & 8'hfc, 8'hf8);
    @(posedge clock) {pa_req, pb_req, rx_req} <= 24'h000000;
    wb(1, OFF_ROUTE, 8'h00);
    wb(1, OFF_DIR, 8'h00);
    ext_val <= 8'h00;
    wb(1, OFF_EDGE_SEL, 8'hff);
    wb(1, OFF_IRQ_FLAG, 8'hff);
    wb(1, OFF_IRQ_EN, 8'h01);
    ext_val <= 8'h01;
    repeat (6) @(posedge clock);
    wb(1, OFF_IRQ_FLAG, 8'h00);
    wb(0, OFF_IRQ_FLAG, 8'h00, 8'h01);
    @(negedge clock);
    check(port_irq, 1'b1);
    wb(1, OFF_IRQ_FLAG, 8'h01);
    wb(0, OFF_IRQ_FLAG, 8'h00, 8'h00);
    @(negedge clock);
    check(port_irq, 1'b0);
    wb(1, OFF_DATA, 8'h02);
    wb(1, OFF_DIR, 8'h02);
    repeat (6) @(posedge clock);
    wb(0, OFF_IRQ_FLAG, 8'h00, 8'h02);
    check(wakes, 1);
    @(posedge clock) srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    check(pad_oe, 8'h00);
    wb(0, OFF_PKG_CODE, 8'h00, 8'h00);
    wb(1, OFF_PKG_CODE, 8'h06);
    wb(0, OFF_PKG_CODE, 8'h00, 8'h06);
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule : port_pin_logic_test
`default_nettype wire
